// *** design/daio_pkg.sv ***
// constants, register map and field layout of the dual analog io scaler
// assumes a 200 MHz ref_clk and an avalon-mm master using byte addresses
`default_nettype none
package daio_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_IN_COMP_OFS  = 6'h11;
    localparam logic [5:0] IDX_IN_COMP_GAIN = 6'h12;
    localparam logic [5:0] IDX_OUT_COMP_OFS = 6'h13;
    localparam logic [5:0] IDX_OUT_COMP_GAIN = 6'h14;
    localparam logic [5:0] IDX_FEATURE      = 6'h20;
    localparam logic [5:0] IDX_IN_USER_OFS  = 6'h21;
    localparam logic [5:0] IDX_IN_USER_GAIN = 6'h22;
    localparam logic [5:0] IDX_OUT_USER_OFS = 6'h24;
    localparam logic [5:0] IDX_OUT_USER_GAIN = 6'h25;
    localparam logic [5:0] IDX_IRQ_STATUS   = 6'h28;
    localparam logic [5:0] IDX_IRQ_MASK     = 6'h29;
    localparam logic [5:0] IDX_RUN_STATUS   = 6'h2A;
    // feature_config fields
    localparam int FEAT_USER_EN    = 0;
    localparam int FEAT_FACTORY_EN = 1;
    localparam int FEAT_ALT_FMT    = 2;
    localparam logic [15:0] FEATURE_RESET = 16'h0002;
    // gain is signed q2.14, so 0x4000 is unity
    localparam int GAIN_FRAC = 14;
    localparam logic [15:0] GAIN_RESET = 16'h4000;
    localparam logic [15:0] OFS_RESET  = 16'h0000;
    // interrupt event bits
    localparam int EV_WATCHDOG = 0;
    localparam int EV_IN_OVR   = 1;
    localparam int EV_OUT_OVR  = 2;
    localparam int EV_WIDTH    = 3;
    // status byte fields
    localparam int STAT_RUN = 0;
    localparam int STAT_OVR = 1;
    // converter width and saturation limits
    localparam int ADC_BITS = 12;
    localparam logic signed [33:0] SAT_MAX = 34'sh000007FFF;
    localparam logic signed [33:0] SAT_MIN = 34'sh3FFFF8000;
    // watchdog time
    localparam int WD_TIME_MS  = 100;
    localparam int REF_CLK_MHZ = 200;
    localparam int WD_CYCLES_DEFAULT = WD_TIME_MS * 1000 * REF_CLK_MHZ;
    localparam int WD_CNT_BITS = 25;
endpackage : daio_pkg
`default_nettype wire

// *** design/daio_top.sv ***
// two-in two-out analog terminal process-data path with register file
// assumes avalon-mm master on ref_clk and converters synchronous to it
//
// How it works
// R01: two inputs and two outputs, each converted at twelve bits.
// R02: input image is two data words plus two status bytes.
// R03: output image of two data words and two control bytes is accepted.
// R04: four run indicators, one per channel, lit in normal operation.
// R05: no exchange for over 100 ms expires watchdog, indicators go off.
// R06: two's complement is the reset default both ways.
// R07: a feature_config bit selects sign-magnitude instead.
// R08: input full scale maps -10 V to 0x8000 and +10 V to 0x7FFF; the top twelve-bit sample reaches only 0x7FF0.
// R09: output word 0x8000 gives -10 V, 0x7FFF gives +10 V.
// R10: input adds comp offset to raw value, then multiplies by comp gain.
// R11: with no scaling enabled the compensated value passes straight through.
// R12: input user scaling gives user offset plus user gain times value.
// R13: factory scaling first, then user scaling on its result.
// R14: factory scaling is enabled after reset though it has no coefficients.
// R15: output word is value times comp gain plus comp offset.
// R16: output user scaling runs before output compensation.
// R17: feature_config enables select the active stages for both directions.
// R18: factory stage is a unit-gain zero-offset pass-through when enabled.
// R19: every scaled result saturates to the signed sixteen-bit range.
`default_nettype none
module daio_top
    import daio_pkg::*;
#(
    parameter int unsigned WD_CYCLES = WD_CYCLES_DEFAULT
) (
    // clock and reset
    input  wire logic                ref_clk,
    input  wire logic                rst,
    // avalon-mm register slave
    input  wire logic [7:0]          address,
    input  wire logic                read,
    input  wire logic                write,
    input  wire logic [31:0]         writedata,
    input  wire logic [3:0]          byteenable,
    output logic      [31:0]         readdata,
    output logic                     waitrequest,
    // a/d converters
    input  wire logic                adc_valid,
    input  wire logic [ADC_BITS-1:0] adc_data_0,
    input  wire logic [ADC_BITS-1:0] adc_data_1,
    // d/a converters
    output logic      [ADC_BITS-1:0] dac_data_0,
    output logic      [ADC_BITS-1:0] dac_data_1,
    output logic                     dac_load,
    // coupler: output image in
    input  wire logic                pd_out_valid,
    input  wire logic [15:0]         pd_out_word_0,
    input  wire logic [15:0]         pd_out_word_1,
    input  wire logic [7:0]          pd_ctrl_0,
    input  wire logic [7:0]          pd_ctrl_1,
    // coupler: input image out
    output logic      [15:0]         pd_in_word_0,
    output logic      [15:0]         pd_in_word_1,
    output logic      [7:0]          pd_status_0,
    output logic      [7:0]          pd_status_1,
    // indicators and interrupt
    output logic      [3:0]          run_led,
    output logic                     irq
);

    ////////////////////////////////////////////////////////////////////
    // arithmetic helpers
    // saturate a wide result; bit 16 flags that clipping occurred
    function automatic logic [16:0] sat16(input logic signed [33:0] v);
        logic [16:0] r;
        r = {1'b0, v[15:0]};
        if (v > SAT_MAX) r = {1'b1, 16'h7FFF};
        if (v < SAT_MIN) r = {1'b1, 16'h8000};
        return r;
    endfunction
    // saturated sum of two signed words
    function automatic logic [16:0] add_s(input logic [15:0] a, input logic [15:0] b);
        logic signed [33:0] s;
        s = 34'(signed'(a)) + 34'(signed'(b));
        return sat16(s);
    endfunction
    // saturated product with a q2.14 gain
    function automatic logic [16:0] mul_g(input logic [15:0] x, input logic [15:0] g);
        logic signed [33:0] p;
        p = 34'(signed'(x)) * 34'(signed'(g));
        return sat16(p >>> GAIN_FRAC);
    endfunction
    // two's complement to the alternative sign-magnitude form
    function automatic logic [15:0] to_fmt(input logic [15:0] v, input logic alt);
        logic [15:0] r;
        r = v;
        // -32768 has no magnitude in 15 bits, so it clips
        if (alt && v[15]) r = (v == 16'h8000) ? 16'hFFFF : {1'b1, 15'(16'h0000 - v)};
        return r;
    endfunction
    // alternative form back to two's complement
    function automatic logic [15:0] from_fmt(input logic [15:0] w, input logic alt);
        logic [15:0] r;
        r = w;
        if (alt && w[15]) r = 16'h0000 - {1'b0, w[14:0]};
        return r;
    endfunction
    // byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [15:0] r;
        r = old;
        if (be[0]) r[7:0] = wd[7:0];
        if (be[1]) r[15:8] = wd[15:8];
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // register file and bus slave
    logic [15:0]          in_comp_offset, next_in_comp_offset;
    logic [15:0]          in_comp_gain, next_in_comp_gain;
    logic [15:0]          out_comp_offset, next_out_comp_offset;
    logic [15:0]          out_comp_gain, next_out_comp_gain;
    logic [15:0]          feature_config, next_feature_config;
    logic [15:0]          in_user_offset, next_in_user_offset;
    logic [15:0]          in_user_gain, next_in_user_gain;
    logic [15:0]          out_user_offset, next_out_user_offset;
    logic [15:0]          out_user_gain, next_out_user_gain;
    logic [EV_WIDTH-1:0]  irq_status, next_irq_status;
    logic [EV_WIDTH-1:0]  irq_mask, next_irq_mask;
    logic [31:0]          next_readdata;
    logic                 next_waitrequest;
    logic                 next_irq;
    logic [EV_WIDTH-1:0]  events;
    logic                 wd_expired;
    logic [7:0]           ctrl_0, ctrl_1;
    logic [5:0]           idx;
    logic                 wr_go;

    assign idx   = address[7:2];
    assign wr_go = write && !waitrequest;

    // one wait state per access; read data is registered on the edge that drops waitrequest, a write lands one edge later
    always_comb begin
        next_in_comp_offset  = in_comp_offset;
        next_in_comp_gain    = in_comp_gain;
        next_out_comp_offset = out_comp_offset;
        next_out_comp_gain   = out_comp_gain;
        next_feature_config  = feature_config;
        next_in_user_offset  = in_user_offset;
        next_in_user_gain    = in_user_gain;
        next_out_user_offset = out_user_offset;
        next_out_user_gain   = out_user_gain;
        next_irq_mask        = irq_mask;
        next_irq_status      = irq_status;
        next_waitrequest     = !((read || write) && waitrequest);
        next_readdata        = readdata;
        if (wr_go) begin
            unique case (idx)
                IDX_IN_COMP_OFS:   next_in_comp_offset  = merge(in_comp_offset, writedata, byteenable);
                IDX_IN_COMP_GAIN:  next_in_comp_gain    = merge(in_comp_gain, writedata, byteenable);
                IDX_OUT_COMP_OFS:  next_out_comp_offset = merge(out_comp_offset, writedata, byteenable);
                IDX_OUT_COMP_GAIN: next_out_comp_gain   = merge(out_comp_gain, writedata, byteenable);
                // R17 stage enables
                IDX_FEATURE:       next_feature_config  = merge(feature_config, writedata, byteenable);
                IDX_IN_USER_OFS:   next_in_user_offset  = merge(in_user_offset, writedata, byteenable);
                IDX_IN_USER_GAIN:  next_in_user_gain    = merge(in_user_gain, writedata, byteenable);
                IDX_OUT_USER_OFS:  next_out_user_offset = merge(out_user_offset, writedata, byteenable);
                IDX_OUT_USER_GAIN: next_out_user_gain   = merge(out_user_gain, writedata, byteenable);
                IDX_IRQ_MASK:      if (byteenable[0]) next_irq_mask = writedata[EV_WIDTH-1:0];
                IDX_IRQ_STATUS:    if (byteenable[0]) next_irq_status = irq_status & ~writedata[EV_WIDTH-1:0];
                default: ;
            endcase
        end
        // new events win over a clear in the same cycle
        next_irq_status = next_irq_status | events;
        if (read && waitrequest) begin
            unique case (idx)
                IDX_IN_COMP_OFS:   next_readdata = 32'(in_comp_offset);
                IDX_IN_COMP_GAIN:  next_readdata = 32'(in_comp_gain);
                IDX_OUT_COMP_OFS:  next_readdata = 32'(out_comp_offset);
                IDX_OUT_COMP_GAIN: next_readdata = 32'(out_comp_gain);
                IDX_FEATURE:       next_readdata = 32'(feature_config);
                IDX_IN_USER_OFS:   next_readdata = 32'(in_user_offset);
                IDX_IN_USER_GAIN:  next_readdata = 32'(in_user_gain);
                IDX_OUT_USER_OFS:  next_readdata = 32'(out_user_offset);
                IDX_OUT_USER_GAIN: next_readdata = 32'(out_user_gain);
                IDX_IRQ_STATUS:    next_readdata = 32'(irq_status);
                IDX_IRQ_MASK:      next_readdata = 32'(irq_mask);
                IDX_RUN_STATUS:    next_readdata = {ctrl_1, ctrl_0, 11'h000, wd_expired, run_led};
                default:           next_readdata = 32'h00000000;
            endcase
        end
        next_irq = |(next_irq_status & next_irq_mask);
    end

    // register file state
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            in_comp_offset  <= OFS_RESET;
            in_comp_gain    <= GAIN_RESET;
            out_comp_offset <= OFS_RESET;
            out_comp_gain   <= GAIN_RESET;
            // R06 R14 two's complement, factory stage on
            feature_config  <= FEATURE_RESET;
            in_user_offset  <= OFS_RESET;
            in_user_gain    <= GAIN_RESET;
            out_user_offset <= OFS_RESET;
            out_user_gain   <= GAIN_RESET;
            irq_status      <= '0;
            irq_mask        <= '0;
            readdata        <= 32'h00000000;
            waitrequest     <= 1'b1;
            irq             <= 1'b0;
        end else begin
            in_comp_offset  <= next_in_comp_offset;
            in_comp_gain    <= next_in_comp_gain;
            out_comp_offset <= next_out_comp_offset;
            out_comp_gain   <= next_out_comp_gain;
            feature_config  <= next_feature_config;
            in_user_offset  <= next_in_user_offset;
            in_user_gain    <= next_in_user_gain;
            out_user_offset <= next_out_user_offset;
            out_user_gain   <= next_out_user_gain;
            irq_status      <= next_irq_status;
            irq_mask        <= next_irq_mask;
            readdata        <= next_readdata;
            waitrequest     <= next_waitrequest;
            irq             <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // process-data watchdog
    logic [WD_CNT_BITS-1:0] wd_count, next_wd_count;
    logic                   next_wd_expired;
    logic [3:0]             next_run_led;
    logic                   wd_event;

    // every output image from the coupler counts as an exchange
    always_comb begin
        next_wd_count   = wd_count;
        next_wd_expired = wd_expired;
        wd_event        = 1'b0;
        if (pd_out_valid) begin
            next_wd_count   = '0;
            next_wd_expired = 1'b0;
        // R05 overflow after the timeout
        end else if (!wd_expired) begin
            if (wd_count == WD_CNT_BITS'(WD_CYCLES - 1)) begin
                next_wd_expired = 1'b1;
                wd_event        = 1'b1;
            end else begin
                next_wd_count = wd_count + 1'b1;
            end
        end
        // R04 lit only while running
        next_run_led = {4{!next_wd_expired}};
    end

    // leds stay dark until the first exchange
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wd_count   <= '0;
            wd_expired <= 1'b1;
            run_led    <= 4'h0;
        end else begin
            wd_count   <= next_wd_count;
            wd_expired <= next_wd_expired;
            run_led    <= next_run_led;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // scaling datapath, both channels per direction
    logic [15:0] adc_x [2];
    logic [15:0] pd_x [2];
    logic [15:0] in_y [2];
    logic [15:0] out_y [2];
    logic        in_ovr [2];
    logic        out_ovr [2];
    logic [15:0] next_pd_in_word_0, next_pd_in_word_1;
    logic [7:0]  next_pd_status_0, next_pd_status_1;
    logic [ADC_BITS-1:0] next_dac_data_0, next_dac_data_1;
    logic        next_dac_load;
    logic [7:0]  next_ctrl_0, next_ctrl_1;
    logic        in_ovr_any, out_ovr_any;

    // R01 twelve-bit samples left-justified onto the full-scale word
    assign adc_x[0] = {adc_data_0, 4'h0};
    assign adc_x[1] = {adc_data_1, 4'h0};
    assign pd_x[0]  = pd_out_word_0;
    assign pd_x[1]  = pd_out_word_1;

    // combinational chain; results land in one cycle
    always_comb begin
        logic [16:0] t;
        logic [15:0] v;
        logic        o;
        t = '0;
        v = '0;
        o = 1'b0;
        for (int c = 0; c < 2; c++) begin
            // R10 offset then gain
            t = add_s(in_comp_offset, adc_x[c]);
            o = t[16];
            t = mul_g(t[15:0], in_comp_gain);
            o = o | t[16];
            v = t[15:0];
            // R18 R13 factory stage is identity, ahead of user stage
            // R12 user offset plus gain times value
            if (feature_config[FEAT_USER_EN]) begin
                t = mul_g(v, in_user_gain);
                o = o | t[16];
                t = add_s(in_user_offset, t[15:0]);
                o = o | t[16];
                v = t[15:0];
            end
            // R08 R07 representation of the result
            in_y[c]   = to_fmt(v, feature_config[FEAT_ALT_FMT]);
            in_ovr[c] = o;
            // R09 R07 controller word to signed value
            v = from_fmt(pd_x[c], feature_config[FEAT_ALT_FMT]);
            o = 1'b0;
            // R16 user stage before compensation
            if (feature_config[FEAT_USER_EN]) begin
                t = mul_g(v, out_user_gain);
                o = t[16];
                t = add_s(out_user_offset, t[15:0]);
                o = o | t[16];
                v = t[15:0];
            end
            // R15 gain then offset
            t = mul_g(v, out_comp_gain);
            o = o | t[16];
            // R19 saturated before the converter
            t = add_s(t[15:0], out_comp_offset);
            // R11 no stage enabled leaves only compensation
            out_y[c]   = t[15:0];
            out_ovr[c] = o | t[16];
        end
        in_ovr_any  = in_ovr[0] | in_ovr[1];
        out_ovr_any = out_ovr[0] | out_ovr[1];
    end

    // R02 input image words and status bytes
    always_comb begin
        next_pd_in_word_0 = pd_in_word_0;
        next_pd_in_word_1 = pd_in_word_1;
        next_pd_status_0  = pd_status_0;
        next_pd_status_1  = pd_status_1;
        if (adc_valid) begin
            next_pd_in_word_0 = in_y[0];
            next_pd_in_word_1 = in_y[1];
            next_pd_status_0[STAT_OVR] = in_ovr[0];
            next_pd_status_1[STAT_OVR] = in_ovr[1];
        end
        next_pd_status_0[STAT_RUN] = !next_wd_expired;
        next_pd_status_1[STAT_RUN] = !next_wd_expired;
        // R03 output image accepted with its control bytes
        next_dac_data_0 = dac_data_0;
        next_dac_data_1 = dac_data_1;
        next_ctrl_0     = ctrl_0;
        next_ctrl_1     = ctrl_1;
        next_dac_load   = pd_out_valid;
        if (pd_out_valid) begin
            // the converter keeps the top twelve bits only
            next_dac_data_0 = out_y[0][15:4];
            next_dac_data_1 = out_y[1][15:4];
            next_ctrl_0     = pd_ctrl_0;
            next_ctrl_1     = pd_ctrl_1;
        end
        events = '0;
        events[EV_WATCHDOG] = wd_event;
        events[EV_IN_OVR]   = adc_valid && in_ovr_any;
        events[EV_OUT_OVR]  = pd_out_valid && out_ovr_any;
    end

    // process image and converter registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pd_in_word_0 <= 16'h0000;
            pd_in_word_1 <= 16'h0000;
            pd_status_0  <= 8'h00;
            pd_status_1  <= 8'h00;
            dac_data_0   <= 12'h000;
            dac_data_1   <= 12'h000;
            dac_load     <= 1'b0;
            ctrl_0       <= 8'h00;
            ctrl_1       <= 8'h00;
        end else begin
            pd_in_word_0 <= next_pd_in_word_0;
            pd_in_word_1 <= next_pd_in_word_1;
            pd_status_0  <= next_pd_status_0;
            pd_status_1  <= next_pd_status_1;
            dac_data_0   <= next_dac_data_0;
            dac_data_1   <= next_dac_data_1;
            dac_load     <= next_dac_load;
            ctrl_0       <= next_ctrl_0;
            ctrl_1       <= next_ctrl_1;
        end
    end

endmodule // daio_top
`default_nettype wire

// *** sim/daio_props.sv ***
// port checker for daio_top
// bound by the bench; sees only top ports
`default_nettype none
module daio_props
    import daio_pkg::*;
#(
    parameter int unsigned WD_CYCLES = 64
) (
    // clock and reset
    input wire logic                ref_clk,
    input wire logic                rst,
    // register bus
    input wire logic                read,
    input wire logic                write,
    input wire logic                waitrequest,
    // process data
    input wire logic                adc_valid,
    input wire logic [15:0]         pd_in_word_0,
    input wire logic                pd_out_valid,
    input wire logic [ADC_BITS-1:0] dac_data_0,
    input wire logic                dac_load,
    input wire logic [3:0]          run_led
);
default clocking cb @(posedge ref_clk); endclocking
default disable iff (rst);
////////////////////////////////////////
// idle cycles since last exchange; saturates so it never wraps
int unsigned idle;
int unsigned next_idle;
always_comb begin
    next_idle = idle;
    if (pd_out_valid) next_idle = 0;
    else if (idle < WD_CYCLES + 8) next_idle = idle + 1;
end
always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) idle <= WD_CYCLES + 8;
    else idle <= next_idle;
end
////////////////////////////////////////
wait_one_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer late");
wait_back_a: assert property (!waitrequest |=> waitrequest)
    else $error("bus answer too long");
load_pulse_a: assert property (pd_out_valid |=> dac_load)
    else $error("no converter load");
load_end_a: assert property (!pd_out_valid |=> !dac_load)
    else $error("stray converter load");
led_on_a: assert property (pd_out_valid |=> run_led == 4'hF)
    else $error("leds not lit");
led_live_a: assert property (idle > 0 && idle < WD_CYCLES - 2 |-> run_led == 4'hF)
    else $error("leds off early");
wd_off_a: assert property (idle > WD_CYCLES + 2 |-> run_led == 4'h0)
    else $error("leds on after expiry");
in_hold_a: assert property (!adc_valid |=> $stable(pd_in_word_0))
    else $error("input word moved");
dac_hold_a: assert property (!pd_out_valid |=> $stable(dac_data_0))
    else $error("converter word moved");
cover property (pd_out_valid ##1 dac_load);
cover property ($fell(run_led[0]));
cover property (adc_valid ##1 !adc_valid);
endmodule // daio_props
`default_nettype wire

// *** sim/daio_coupler.sv ***
// coupler model sending the output image
// assumes a bench calling send from its main sequence
`default_nettype none
module daio_coupler (
    // clock
    input wire logic   ref_clk,
    // output image
    output var logic        pd_out_valid,
    output var logic [15:0] pd_out_word_0,
    output var logic [15:0] pd_out_word_1,
    output var logic [7:0]  pd_ctrl_0,
    output var logic [7:0]  pd_ctrl_1
);
initial begin
    pd_out_valid = 1'b0;
    pd_out_word_0 = 16'h0000;
    pd_out_word_1 = 16'h0000;
    pd_ctrl_0 = 8'h00;
    pd_ctrl_1 = 8'h00;
end
// words inverted after release so stale data never match
task automatic send(input logic [15:0] w0, input logic [15:0] w1);
    @(posedge ref_clk);
    pd_out_valid <= 1'b1;
    pd_out_word_0 <= w0;
    pd_out_word_1 <= w1;
    pd_ctrl_0 <= 8'hA5;
    pd_ctrl_1 <= 8'h5A;
    @(posedge ref_clk);
    pd_out_valid <= 1'b0;
    pd_out_word_0 <= ~w0;
    pd_out_word_1 <= ~w1;
endtask
endmodule // daio_coupler
`default_nettype wire

// *** sim/daio_top_bench.sv ***
// bench for daio_top: registers, both paths, irq, watchdog
// shortened watchdog; coupler model drives the output image
`default_nettype none
module daio_top_bench
    import daio_pkg::*;
;
timeunit 1ns;
timeprecision 100ps;
localparam int unsigned WD = 64;
logic        ref_clk, rst, read, write, adc_valid, waitrequest, dac_load, irq, pd_out_valid;
logic [7:0]  address, pd_ctrl_0, pd_ctrl_1, pd_status_0, pd_status_1;
logic [31:0] writedata, readdata;
logic [11:0] adc_data_0, adc_data_1, dac_data_0, dac_data_1;
logic [15:0] pd_out_word_0, pd_out_word_1, pd_in_word_0, pd_in_word_1, q;
logic [3:0]  run_led;
int          bad_count, cmp_count;
daio_top #(.WD_CYCLES(WD)) u_daio_top (.ref_clk(ref_clk), .rst(rst),
    .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(4'hF),
    .readdata(readdata), .waitrequest(waitrequest), .adc_valid(adc_valid),
    .adc_data_0(adc_data_0), .adc_data_1(adc_data_1), .dac_data_0(dac_data_0),
    .dac_data_1(dac_data_1), .dac_load(dac_load), .pd_out_valid(pd_out_valid),
    .pd_out_word_0(pd_out_word_0), .pd_out_word_1(pd_out_word_1), .pd_ctrl_0(pd_ctrl_0),
    .pd_ctrl_1(pd_ctrl_1), .pd_in_word_0(pd_in_word_0), .pd_in_word_1(pd_in_word_1),
    .pd_status_0(pd_status_0), .pd_status_1(pd_status_1), .run_led(run_led), .irq(irq));
daio_coupler u_daio_coupler (.ref_clk(ref_clk), .pd_out_valid(pd_out_valid),
    .pd_out_word_0(pd_out_word_0), .pd_out_word_1(pd_out_word_1),
    .pd_ctrl_0(pd_ctrl_0), .pd_ctrl_1(pd_ctrl_1));
////////////////////////////////////////
// 200 MHz clock and hang guard
initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
end
initial begin
    #50us;
    bad_count++;
    summarize();
end
task summarize;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
endtask
task chk(input logic [15:0] got, input logic [15:0] exp, input string n);
    cmp_count++;
    if (got !== exp) begin
        bad_count++;
        $display("wrong value %s expected %h seen %h", n, exp, got);
    end
endtask
// bus cycles hold the request until waitrequest is sampled low
task wr(input logic [5:0] i, input logic [15:0] d);
    @(posedge ref_clk);
    address <= {i, 2'b00};
    writedata <= {16'h0000, d};
    write <= 1'b1;
    do @(posedge ref_clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
endtask
task rdchk(input logic [5:0] i, input logic [15:0] exp, input string n);
    @(posedge ref_clk);
    address <= {i, 2'b00};
    read <= 1'b1;
    do @(posedge ref_clk); while (waitrequest !== 1'b0);
    q = readdata[15:0];
    read <= 1'b0;
    chk(q, exp, n);
endtask
task adc(input logic [11:0] x0, input logic [11:0] x1);
    @(posedge ref_clk);
    adc_valid <= 1'b1;
    adc_data_0 <= x0;
    adc_data_1 <= x1;
    @(posedge ref_clk);
    adc_valid <= 1'b0;
    #1;
endtask
////////////////////////////////////////
// reset values and map
task t_regs;
    rdchk(IDX_FEATURE, 16'h0002, "feature");
    rdchk(IDX_IN_COMP_GAIN, 16'h4000, "in gain");
    wr(6'h30, 16'hFFFF);
    rdchk(6'h30, 16'h0000, "unmapped");
endtask
task t_in;
    adc(12'h800, 12'h7FF);
    chk(pd_in_word_0, 16'h8000, "in0 low");
    chk(pd_in_word_1, 16'h7FF0, "in1 high");
    wr(IDX_IN_COMP_OFS, 16'h0010);
    wr(IDX_IN_COMP_GAIN, 16'h2000);
    adc(12'h100, 12'h000);
    chk(pd_in_word_0, 16'h0808, "in0 comp");
    wr(IDX_IN_COMP_OFS, 16'h0000);
    wr(IDX_IN_COMP_GAIN, 16'h4000);
endtask
// user scaling, clip and its interrupt
task t_user;
    wr(IDX_IN_USER_OFS, 16'h0100);
    wr(IDX_IN_USER_GAIN, 16'h8000);
    wr(IDX_FEATURE, 16'h0003);
    adc(12'h100, 12'h7FF);
    chk(pd_in_word_0, 16'hE100, "in0 user");
    chk(pd_in_word_1, 16'h8100, "in1 clip");
    chk({15'h0000, pd_status_1[STAT_OVR]}, 16'h0001, "clip flag");
    chk({15'h0000, irq}, 16'h0000, "masked irq");
    wr(IDX_IRQ_MASK, 16'h0002);
    repeat (3) @(posedge ref_clk);
    chk({15'h0000, irq}, 16'h0001, "irq up");
    wr(IDX_IRQ_STATUS, 16'h0007);
    repeat (3) @(posedge ref_clk);
    chk({15'h0000, irq}, 16'h0000, "irq cleared");
endtask
task t_alt;
    wr(IDX_FEATURE, 16'h0006);
    adc(12'hFF0, 12'h010);
    chk(pd_in_word_0, 16'h8100, "alt in0");
    chk(pd_in_word_1, 16'h0100, "alt in1");
    u_daio_coupler.send(16'h8100, 16'h0100);
    #1;
    chk({4'h0, dac_data_0}, 16'h0FF0, "alt dac0");
    wr(IDX_FEATURE, 16'h0002);
endtask
task t_out;
    u_daio_coupler.send(16'h8000, 16'h7FFF);
    #1;
    chk({4'h0, dac_data_0}, 16'h0800, "dac0 low");
    chk({4'h0, dac_data_1}, 16'h07FF, "dac1 high");
    chk({12'h000, run_led}, 16'h000F, "leds lit");
    chk({8'h00, pd_status_0}, 16'h0001, "status0 run");
    wr(IDX_OUT_COMP_OFS, 16'h0100);
    wr(IDX_OUT_COMP_GAIN, 16'h2000);
    u_daio_coupler.send(16'h4000, 16'hC000);
    #1;
    chk({4'h0, dac_data_0}, 16'h0210, "dac0 comp");
    chk({4'h0, dac_data_1}, 16'h0E10, "dac1 comp");
endtask
// expiry turns leds off and flags it
task t_wd;
    repeat (WD + 4) @(posedge ref_clk);
    #1;
    chk({12'h000, run_led}, 16'h0000, "leds expired");
    rdchk(IDX_IRQ_STATUS, 16'h0001, "expiry event");
endtask
////////////////////////////////////////
// reset for two cycles, then the scenarios in order
initial begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0000_0000;
    adc_valid = 1'b0;
    adc_data_0 = 12'h000;
    adc_data_1 = 12'h000;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk({12'h000, run_led}, 16'h0000, "leds at start");
    t_regs();
    t_in();
    t_user();
    t_alt();
    t_out();
    t_wd();
    summarize();
end
endmodule // daio_top_bench
bind daio_top daio_props #(.WD_CYCLES(WD_CYCLES)) u_daio_props (.ref_clk(ref_clk), .rst(rst),
    .read(read), .write(write), .waitrequest(waitrequest), .adc_valid(adc_valid),
    .pd_in_word_0(pd_in_word_0), .pd_out_valid(pd_out_valid), .dac_data_0(dac_data_0),
    .dac_load(dac_load), .run_led(run_led));
`default_nettype wire
